// File: verilog/csa_core_regs.sv
/*
  Status word, primary and secondary arithmetic registers and stack pointer on an APB slave.
  Assumes a single 100 MHz clock, APB master on the same clock, asynchronous active-low reset.
*/
// Operation
// [RQ1] Carry flag set on add carry or subtract borrow, cleared otherwise.
// [RQ2] Nibble carry flag set on carry into or borrow from upper nibble.
// [RQ3] Two general flags at bits five and one, changed only by software.
// [RQ4] Bank select bits choose working bank base 0x00, 0x08, 0x10 or 0x18.
// [RQ5] Range flag set on carry, borrow, or multiply/divide overflow.
// [RQ6] Parity bit follows odd count of ones in primary register, read-only.
// [RQ7] Status word at 0xd0, resets to zero.
// [RQ8] Primary arithmetic register at 0xe0, read/write, resets to zero.
// [RQ9] Secondary arithmetic register at 0xf0, read/write, resets to zero.
// [RQ10] Software never writes one into reserved bits.
// [RQ11] Stack pointer at 0x81, eight bits, resets to 0x07.
// [RQ12] Stack pointer increments before push, decrements after pop.
`timescale 1ns/1ps
`include "csa_regs.svh"
module csa_core_regs
  import csa_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [7:0] BANK_BASE,
  output logic [7:0] STACK_TOP,
  output logic PARITY
);
  initial begin
    if (ADDR_W < 10) begin
      $error("ADDR_W must be at least 10");
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic [7:0] stk_ff;
  logic [7:0] stat_ff;
  logic [7:0] pri_ff;
  logic [7:0] sec_ff;
  logic [7:0] rdata_ff;
  csa_state_e state_ff;
  csa_state_e nxt_state;
  logic access;
  logic wr;
  logic rd;
  logic hit;
  logic lane0;
  logic [7:0] wbyte;
  logic [7:0] word_addr;
  logic up_zero;

  assign up_zero = (ADDR_W > 10) ? (PADDR[ADDR_W-1:2] >> 8) == '0 : 1'b1;
  assign word_addr = PADDR[9:2];
  assign access = PSEL && PENABLE;
  assign wbyte = PWDATA[7:0];
  assign lane0 = PSTRB[0];
  always_comb begin
    hit = 1'b0;
    if (up_zero && PADDR[1:0] == 2'b00) begin
      case (word_addr)
        `CSA_OFF_STK, `CSA_OFF_STAT, `CSA_OFF_PRI, `CSA_OFF_SEC, `CSA_OFF_CTRL, `CSA_OFF_BANK: begin
          hit = 1'b1;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end
  end
  assign wr = access && PWRITE && hit && lane0;
  assign rd = access && !PWRITE && hit;

  // One wait-free access phase; answer comes on the first enable cycle
  always_comb begin
    case (state_ff)
      CSA_ST_IDLE: begin
        nxt_state = (PSEL && !PENABLE) ? CSA_ST_ACCESS : CSA_ST_IDLE;
      end
      CSA_ST_ACCESS: begin
        nxt_state = (PSEL && !PENABLE) ? CSA_ST_ACCESS : CSA_ST_IDLE;
      end
      default: begin
        nxt_state = CSA_ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state_ff <= CSA_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end
  assign PREADY = 1'b1;
  assign PSLVERR = access && !hit;

  // ----------------------------------------------------------------
  // Arithmetic and stack command strobes (control word)
  // ----------------------------------------------------------------
  logic ctl_wr;
  logic do_arith;
  logic do_push;
  logic do_pop;
  logic [1:0] op_sel;
  logic [7:0] alu_res;
  logic [7:0] alu_hi;
  logic alu_carry;
  logic alu_nibc;
  logic alu_range;
  logic par;

  assign ctl_wr = wr && word_addr == `CSA_OFF_CTRL;
  assign do_arith = ctl_wr && wbyte[`CSA_CTL_ARITH];
  assign do_push = ctl_wr && wbyte[`CSA_CTL_PUSH];
  assign do_pop = ctl_wr && wbyte[`CSA_CTL_POP] && !wbyte[`CSA_CTL_PUSH];
  assign op_sel = wbyte[`CSA_CTL_OPHI:`CSA_CTL_OPLO];

  csa_alu #(
    .WIDTH(8)
  ) u_alu (
    .lhs(pri_ff),
    .rhs(sec_ff),
    .op(op_sel),
    .res(alu_res),
    .res_hi(alu_hi),
    .carry(alu_carry),
    .nib_carry(alu_nibc),
    .range(alu_range)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      pri_ff <= `CSA_RST_PRI; // [RQ8]
    end else if (do_arith) begin
      pri_ff <= alu_res; // [RQ8]
    end else if (wr && word_addr == `CSA_OFF_PRI) begin
      pri_ff <= wbyte; // [RQ8]
    end
  end

  // Multiply and divide leave the high half or remainder here
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      sec_ff <= `CSA_RST_SEC; // [RQ9]
    end else if (do_arith && op_sel[1]) begin
      sec_ff <= alu_hi; // [RQ9]
    end else if (wr && word_addr == `CSA_OFF_SEC) begin
      sec_ff <= wbyte; // [RQ9]
    end
  end

  // Parity never stored from the bus; bit 0 kept live from the accumulator
  assign par = ^pri_ff; // [RQ6]
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      stat_ff <= `CSA_RST_STAT; // [RQ7]
    end else if (do_arith) begin
      // Arithmetic wins over a simultaneous software write of the flags
      stat_ff[`CSA_BIT_CARRY] <= op_sel[1] ? 1'b0 : alu_carry; // [RQ1]
      stat_ff[`CSA_BIT_NIBC] <= op_sel[1] ? 1'b0 : alu_nibc; // [RQ2]
      stat_ff[`CSA_BIT_RANGE] <= alu_range; // [RQ5]
    end else if (wr && word_addr == `CSA_OFF_STAT) begin
      stat_ff <= wbyte & `CSA_STAT_WMASK; // [RQ3]
    end
  end

  // Push pre-increments, pop post-decrements: pointer tracks the top entry
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      stk_ff <= `CSA_RST_STK; // [RQ11]
    end else if (do_push) begin
      stk_ff <= stk_ff + 8'h01; // [RQ12]
    end else if (do_pop) begin
      stk_ff <= stk_ff - 8'h01; // [RQ12]
    end else if (wr && word_addr == `CSA_OFF_STK) begin
      stk_ff <= wbyte; // [RQ11]
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] bank_base;
  logic [7:0] rmux;
  assign bank_base = {3'h0, stat_ff[`CSA_BIT_RSH:`CSA_BIT_RSL], 3'h0}; // [RQ4]
  always_comb begin
    case (word_addr)
      `CSA_OFF_STK: rmux = stk_ff;
      `CSA_OFF_STAT: rmux = {stat_ff[7:1], par}; // [RQ6]
      `CSA_OFF_PRI: rmux = pri_ff;
      `CSA_OFF_SEC: rmux = sec_ff;
      `CSA_OFF_BANK: rmux = bank_base;
      default: rmux = 8'h00;
    endcase
  end
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_ff <= 8'h00;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      rdata_ff <= rmux;
    end
  end
  assign PRDATA = {24'h0, rdata_ff};
  assign BANK_BASE = bank_base;
  assign STACK_TOP = stk_ff;
  assign PARITY = par;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_carry_add;
    @(posedge CLOCK) disable iff (!RSTN)
    do_arith && op_sel == CSA_OP_ADD |=> stat_ff[`CSA_BIT_CARRY] == ($past(pri_ff) + $past(sec_ff) > 9'd255);
  endproperty
  a_carry_add: assert property (p_carry_add) else $error("carry wrong after add"); // [RQ1]
  property p_carry_sub;
    @(posedge CLOCK) disable iff (!RSTN)
    do_arith && op_sel == CSA_OP_SUB |=> stat_ff[`CSA_BIT_CARRY] == ($past(pri_ff) < $past(sec_ff));
  endproperty
  a_carry_sub: assert property (p_carry_sub) else $error("borrow wrong after subtract"); // [RQ1]
  property p_muldiv_clear;
    @(posedge CLOCK) disable iff (!RSTN)
    do_arith && op_sel[1] |=> !stat_ff[`CSA_BIT_CARRY] && !stat_ff[`CSA_BIT_NIBC];
  endproperty
  a_muldiv_clear: assert property (p_muldiv_clear) else $error("carry flags not cleared"); // [RQ1]
  property p_nib;
    @(posedge CLOCK) disable iff (!RSTN)
    do_arith && op_sel == CSA_OP_ADD |=> stat_ff[`CSA_BIT_NIBC] == (($past(pri_ff) & 8'h0f) + ($past(sec_ff) & 8'h0f) > 8'h0f);
  endproperty
  a_nib: assert property (p_nib) else $error("nibble carry wrong"); // [RQ2]
  property p_nib_sub;
    @(posedge CLOCK) disable iff (!RSTN)
    do_arith && op_sel == CSA_OP_SUB |=> stat_ff[`CSA_BIT_NIBC] == (($past(pri_ff) & 8'h0f) < ($past(sec_ff) & 8'h0f));
  endproperty
  a_nib_sub: assert property (p_nib_sub) else $error("nibble borrow wrong"); // [RQ2]
  property p_user_flags;
    @(posedge CLOCK) disable iff (!RSTN)
    !(wr && word_addr == `CSA_OFF_STAT) |=> $stable(stat_ff[`CSA_BIT_UFZ]) && $stable(stat_ff[`CSA_BIT_UFO]);
  endproperty
  a_user_flags: assert property (p_user_flags) else $error("user flag changed without write"); // [RQ3]
  property p_user_write;
    @(posedge CLOCK) disable iff (!RSTN)
    wr && word_addr == `CSA_OFF_STAT |=> stat_ff[`CSA_BIT_UFZ] == $past(wbyte[`CSA_BIT_UFZ]) && stat_ff[`CSA_BIT_UFO] == $past(wbyte[`CSA_BIT_UFO]);
  endproperty
  a_user_write: assert property (p_user_write) else $error("user flag write lost"); // [RQ3]
  property p_bank;
    @(posedge CLOCK) disable iff (!RSTN)
    BANK_BASE == 8'(stat_ff[`CSA_BIT_RSH:`CSA_BIT_RSL] * 8);
  endproperty
  a_bank: assert property (p_bank) else $error("bank base mismatch"); // [RQ4]

  // ----------------------------------------------------------------
  // Range, parity and data checks
  // ----------------------------------------------------------------
  property p_range_mul;
    @(posedge CLOCK) disable iff (!RSTN)
    do_arith && op_sel == CSA_OP_MUL |=> stat_ff[`CSA_BIT_RANGE] == ($past(pri_ff) * $past(sec_ff) > 16'd255);
  endproperty
  a_range_mul: assert property (p_range_mul) else $error("range flag wrong after multiply"); // [RQ5]
  property p_range_addsub;
    @(posedge CLOCK) disable iff (!RSTN)
    do_arith && !op_sel[1] |=> stat_ff[`CSA_BIT_RANGE] == stat_ff[`CSA_BIT_CARRY];
  endproperty
  a_range_addsub: assert property (p_range_addsub) else $error("range flag differs from carry"); // [RQ5]
  property p_div_zero;
    @(posedge CLOCK) disable iff (!RSTN)
    do_arith && op_sel == CSA_OP_DIV && sec_ff == 8'h00 |=> stat_ff[`CSA_BIT_RANGE] && pri_ff == $past(pri_ff);
  endproperty
  a_div_zero: assert property (p_div_zero) else $error("divide by zero handled wrong"); // [RQ5]
  property p_parity;
    @(posedge CLOCK) disable iff (!RSTN)
    $changed(pri_ff) |-> PARITY == ^pri_ff && $countones(pri_ff) % 2 == int'(PARITY);
  endproperty
  a_parity: assert property (p_parity) else $error("parity mismatch"); // [RQ6]
  property p_par_store;
    @(posedge CLOCK) disable iff (!RSTN)
    stat_ff[`CSA_BIT_PAR] == 1'b0;
  endproperty
  a_par_store: assert property (p_par_store) else $error("parity bit stored from bus"); // [RQ6]
  property p_acc_write;
    @(posedge CLOCK) disable iff (!RSTN)
    wr && word_addr == `CSA_OFF_PRI && !do_arith |=> pri_ff == $past(wbyte);
  endproperty
  a_acc_write: assert property (p_acc_write) else $error("primary register write lost"); // [RQ8]
  property p_add_res;
    @(posedge CLOCK) disable iff (!RSTN)
    do_arith && op_sel == CSA_OP_ADD |=> pri_ff == 8'($past(pri_ff) + $past(sec_ff));
  endproperty
  a_add_res: assert property (p_add_res) else $error("sum wrong"); // [RQ8]
  property p_sub_res;
    @(posedge CLOCK) disable iff (!RSTN)
    do_arith && op_sel == CSA_OP_SUB |=> pri_ff == 8'($past(pri_ff) - $past(sec_ff));
  endproperty
  a_sub_res: assert property (p_sub_res) else $error("difference wrong"); // [RQ8]
  property p_div_quot;
    @(posedge CLOCK) disable iff (!RSTN)
    do_arith && op_sel == CSA_OP_DIV && sec_ff != 8'h00 |=> pri_ff == $past(pri_ff) / $past(sec_ff);
  endproperty
  a_div_quot: assert property (p_div_quot) else $error("quotient wrong"); // [RQ8]
  property p_sec_write;
    @(posedge CLOCK) disable iff (!RSTN)
    wr && word_addr == `CSA_OFF_SEC |=> sec_ff == $past(wbyte);
  endproperty
  a_sec_write: assert property (p_sec_write) else $error("secondary register write lost"); // [RQ9]
  property p_sec_mul;
    @(posedge CLOCK) disable iff (!RSTN)
    do_arith && op_sel == CSA_OP_MUL |=> sec_ff == 8'((16'($past(pri_ff)) * 16'($past(sec_ff))) >> 8);
  endproperty
  a_sec_mul: assert property (p_sec_mul) else $error("product high byte wrong"); // [RQ9]

  // ----------------------------------------------------------------
  // Stack and read checks
  // ----------------------------------------------------------------
  property p_push;
    @(posedge CLOCK) disable iff (!RSTN)
    do_push |=> stk_ff == 8'($past(stk_ff) + 1);
  endproperty
  a_push: assert property (p_push) else $error("push did not increment"); // [RQ12]
  property p_pop;
    @(posedge CLOCK) disable iff (!RSTN)
    do_pop |=> stk_ff == 8'($past(stk_ff) - 1);
  endproperty
  a_pop: assert property (p_pop) else $error("pop did not decrement"); // [RQ12]
  property p_stk_write;
    @(posedge CLOCK) disable iff (!RSTN)
    wr && word_addr == `CSA_OFF_STK |=> stk_ff == $past(wbyte);
  endproperty
  a_stk_write: assert property (p_stk_write) else $error("stack pointer write lost"); // [RQ11]
  property p_psw_read;
    @(posedge CLOCK) disable iff (!RSTN)
    PSEL && !PENABLE && !PWRITE && word_addr == `CSA_OFF_STAT ##1 PENABLE |-> PRDATA[0] == $past(par);
  endproperty
  a_psw_read: assert property (p_psw_read) else $error("status read parity wrong"); // [RQ7]
endmodule : csa_core_regs

// File: verilog/csa_regs.svh
/*
  Register offsets, field positions and reset values of the status and accumulator block.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef CSA_REGS_SVH
`define CSA_REGS_SVH
`define CSA_OFF_STK 8'h81
`define CSA_OFF_STAT 8'hd0
`define CSA_OFF_PRI 8'he0
`define CSA_OFF_SEC 8'hf0
`define CSA_OFF_CTRL 8'hc0
`define CSA_OFF_BANK 8'hc4
`define CSA_RST_STK 8'h07
`define CSA_RST_STAT 8'h00
`define CSA_RST_PRI 8'h00
`define CSA_RST_SEC 8'h00
`define CSA_BIT_CARRY 7
`define CSA_BIT_NIBC 6
`define CSA_BIT_UFZ 5
`define CSA_BIT_RSH 4
`define CSA_BIT_RSL 3
`define CSA_BIT_RANGE 2
`define CSA_BIT_UFO 1
`define CSA_BIT_PAR 0
`define CSA_STAT_WMASK 8'hfe
`define CSA_NIB_MSB 4
`define CSA_BANK_SHIFT 3
`define CSA_CTL_PUSH 0
`define CSA_CTL_POP 1
`define CSA_CTL_OPLO 2
`define CSA_CTL_OPHI 3
`define CSA_CTL_ARITH 4
`endif

// File: verilog/csa_pkg.sv
/*
  Types of the status and accumulator block.
  Assumes the register header sits beside it.
*/
`include "csa_regs.svh"
package csa_pkg;
  typedef enum logic [1:0] {
    CSA_OP_ADD = 2'b00,
    CSA_OP_SUB = 2'b01,
    CSA_OP_MUL = 2'b10,
    CSA_OP_DIV = 2'b11
  } csa_op_e;
  typedef enum logic [1:0] {
    CSA_ST_IDLE = 2'b00,
    CSA_ST_ACCESS = 2'b01
  } csa_state_e;
endpackage : csa_pkg

// File: verilog/csa_alu.sv
/*
  Arithmetic unit producing a result and the carry, nibble-carry and range flags.
  Assumes the caller latches outputs when it fires the operation.
*/
`timescale 1ns/1ps
`include "csa_regs.svh"
module csa_alu
  import csa_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] lhs,
  input wire logic [WIDTH-1:0] rhs,
  input wire logic [1:0] op,
  output logic [WIDTH-1:0] res,
  output logic [WIDTH-1:0] res_hi,
  output logic carry,
  output logic nib_carry,
  output logic range
);
  initial begin
    if (WIDTH != 8) begin
      $error("csa_alu serves only WIDTH 8");
    end
  end
  logic [WIDTH:0] wide;
  logic [`CSA_NIB_MSB:0] nib;
  logic [2*WIDTH-1:0] prod;
  always_comb begin
    wide = '0;
    nib = '0;
    prod = '0;
    res = '0;
    res_hi = '0;
    carry = 1'b0;
    nib_carry = 1'b0;
    range = 1'b0;
    case (op)
      CSA_OP_ADD: begin
        wide = {1'b0, lhs} + {1'b0, rhs};
        nib = {1'b0, lhs[`CSA_NIB_MSB-1:0]} + {1'b0, rhs[`CSA_NIB_MSB-1:0]};
        res = wide[WIDTH-1:0];
        carry = wide[WIDTH];
        nib_carry = nib[`CSA_NIB_MSB];
        range = wide[WIDTH];
      end
      CSA_OP_SUB: begin
        wide = {1'b0, lhs} - {1'b0, rhs};
        nib = {1'b0, lhs[`CSA_NIB_MSB-1:0]} - {1'b0, rhs[`CSA_NIB_MSB-1:0]};
        res = wide[WIDTH-1:0];
        carry = wide[WIDTH];
        nib_carry = nib[`CSA_NIB_MSB];
        range = wide[WIDTH];
      end
      CSA_OP_MUL: begin
        prod = lhs * rhs;
        res = prod[WIDTH-1:0];
        res_hi = prod[2*WIDTH-1:WIDTH];
        range = |prod[2*WIDTH-1:WIDTH];
      end
      CSA_OP_DIV: begin
        // Divide by zero leaves operands untouched and flags range
        if (rhs == '0) begin
          res = lhs;
          res_hi = rhs;
          range = 1'b1;
        end else begin
          res = lhs / rhs;
          res_hi = lhs % rhs;
        end
      end
      default: begin
        res = '0;
      end
    endcase
  end
endmodule : csa_alu

// File: test/tb_top.sv
/*
  Self-checking bench for the status, accumulator and stack pointer block.
  Assumes the register header and package are compiled first; APB slave answers with zero wait states.
*/
`timescale 1ns/1ps
`include "csa_regs.svh"
module tb_top
  import csa_pkg::*;
;
  logic CLOCK = 1'b0;
  logic RSTN = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [3:0] PSTRB = 4'h0;
  wire logic [31:0] PRDATA;
  wire logic PREADY;
  wire logic PSLVERR;
  wire logic [7:0] BANK_BASE;
  wire logic [7:0] STACK_TOP;
  wire logic PARITY;
  int mismatches = 0;
  int tests_run = 0;
  logic [31:0] rd;
  logic err;

  csa_core_regs #(.ADDR_W(12)) i_dut (.CLOCK(CLOCK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .BANK_BASE(BANK_BASE), .STACK_TOP(STACK_TOP), .PARITY(PARITY));

  always #5 CLOCK = ~CLOCK;

  // ------------------------------------------------------------
  // Bus and compare helpers
  // ------------------------------------------------------------
  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ba

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Request held until PREADY is sampled high at a rising edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= ba(idx);
    PWDATA <= d;
    PSTRB <= 4'hf;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
  endtask : apb

  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, {24'h0, exp});
  endtask : rchk

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rchk(`CSA_OFF_STK, 8'h07);
    rchk(`CSA_OFF_STAT, 8'h00);
    rchk(`CSA_OFF_PRI, 8'h00);
    rchk(`CSA_OFF_SEC, 8'h00);
    chk({24'h0, STACK_TOP}, 32'h07);
  endtask : t_reset

  task automatic t_regs();
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = 8'h5a + 8'(i * 7);
      apb(1'b1, `CSA_OFF_PRI, {24'h0, v});
      apb(1'b1, `CSA_OFF_SEC, {24'h0, ~v});
      rchk(`CSA_OFF_PRI, v);
      rchk(`CSA_OFF_SEC, ~v);
      chk({31'h0, PARITY}, {31'h0, ^v});
      apb(1'b1, `CSA_OFF_STAT, {24'h0, 3'b000, 2'(i), 3'b001});
      rchk(`CSA_OFF_STAT, {3'b000, 2'(i), 2'b00, ^v});
      chk({24'h0, BANK_BASE}, 32'(i * 8));
      rchk(`CSA_OFF_BANK, 8'(i * 8));
    end
    // Parity bit ignores writes and tracks the primary register
    apb(1'b1, `CSA_OFF_STAT, 32'hff);
    rchk(`CSA_OFF_STAT, {7'h7f, ^v});
  endtask : t_regs

  task automatic arith(input logic [7:0] a, input logic [7:0] b, input csa_op_e op,
                       input logic [7:0] er, input logic [7:0] es, input logic [2:0] f);
    apb(1'b1, `CSA_OFF_PRI, {24'h0, a});
    apb(1'b1, `CSA_OFF_SEC, {24'h0, b});
    apb(1'b1, `CSA_OFF_STAT, 32'h22);
    apb(1'b1, `CSA_OFF_CTRL, {27'h0, 1'b1, op, 2'b00});
    rchk(`CSA_OFF_PRI, er);
    rchk(`CSA_OFF_SEC, es);
    rchk(`CSA_OFF_STAT, {f[2], f[1], 1'b1, 2'b00, f[0], 1'b1, ^er});
  endtask : arith

  task automatic t_arith();
    arith(8'h8f, 8'h71, CSA_OP_ADD, 8'h00, 8'h71, 3'b111);
    arith(8'h01, 8'h02, CSA_OP_ADD, 8'h03, 8'h02, 3'b000);
    arith(8'h10, 8'h01, CSA_OP_SUB, 8'h0f, 8'h01, 3'b010);
    arith(8'h00, 8'h01, CSA_OP_SUB, 8'hff, 8'h01, 3'b111);
    arith(8'h10, 8'h20, CSA_OP_MUL, 8'h00, 8'h02, 3'b001);
    arith(8'h07, 8'h02, CSA_OP_DIV, 8'h03, 8'h01, 3'b000);
    arith(8'h09, 8'h00, CSA_OP_DIV, 8'h09, 8'h00, 3'b001);
  endtask : t_arith

  task automatic t_stack();
    apb(1'b1, `CSA_OFF_STK, 32'hfe);
    apb(1'b1, `CSA_OFF_CTRL, 32'h1);
    rchk(`CSA_OFF_STK, 8'hff);
    apb(1'b1, `CSA_OFF_CTRL, 32'h1);
    rchk(`CSA_OFF_STK, 8'h00);
    apb(1'b1, `CSA_OFF_CTRL, 32'h2);
    rchk(`CSA_OFF_STK, 8'hff);
    apb(1'b1, `CSA_OFF_CTRL, 32'h3);
    rchk(`CSA_OFF_STK, 8'h00);
    chk({24'h0, STACK_TOP}, 32'h00);
  endtask : t_stack

  // Unmapped word errors and reads zero; control word reads zero
  task automatic t_unmapped();
    apb(1'b1, 8'h01, 32'hff);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h01, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    rchk(`CSA_OFF_CTRL, 8'h00);
    chk({31'h0, err}, 32'h0);
  endtask : t_unmapped

  // ------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (2) @(posedge CLOCK);
    RSTN <= 1'b1;
    @(posedge CLOCK);
    t_reset();
    t_regs();
    t_arith();
    t_stack();
    t_unmapped();
    final_report();
  end

  // Whole run needs well under 1000 cycles
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
endmodule : tb_top
